// ---- kbr_assertions.sv ----
// Purpose: Port assertions for kbr_receiver
// Assumes: 10 MHz clk, async active-high rst
// Notes:   Bound after the module
`timescale 1ns/1ps
`default_nettype none
module kbr_chk (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       kbd_clock_in,
    input wire logic       irq_clear_in,
    input wire logic       host_select,
    input wire logic [7:0] host_read_bus_out,
    input wire logic       host_read_bus_oe,
    input wire logic       valid,
    input wire logic       interrupt,
    input wire logic       fifo_nonempty
);
    // Raw high time of the keyboard clock, saturating
    logic [9:0] hi_r;
    always_ff @(posedge clk or posedge rst)
        if (rst) hi_r <= 10'h0;
        else hi_r <= kbd_clock_in ? hi_r + {9'h0, ~&hi_r} : 10'h0;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    AST_VONE: assert property (valid |=> !valid) else $error("wide valid");
    // Slack above 500 covers sync and debounce lag
    AST_VIDLE: assert property (valid |-> hi_r >= 10'h1f4 && hi_r <= 10'h208)
        else $error("idle time");
    AST_ISET: assert property (valid |-> interrupt) else $error("irq set");
    AST_IHOLD: assert property (!irq_clear_in [*4] ##0 interrupt |=> interrupt)
        else $error("irq drop");
    AST_NSET: assert property (valid |-> fifo_nonempty) else $error("empty");
    AST_OEON: assert property (host_select [*3] |=> host_read_bus_oe) else $error("oe");
    AST_OEOFF: assert property (!host_select [*4] |-> !host_read_bus_oe) else $error("oe");
    AST_POP: assert property (!host_select [*4] |-> $stable(host_read_bus_out))
        else $error("pop");
endmodule
bind kbr_receiver kbr_chk kbr_chk_i (.clk(clk), .rst(rst), .kbd_clock_in(kbd_clock_in),
    .irq_clear_in(irq_clear_in), .host_select(host_select),
    .host_read_bus_out(host_read_bus_out), .host_read_bus_oe(host_read_bus_oe),
    .valid(valid), .interrupt(interrupt), .fifo_nonempty(fifo_nonempty));
`default_nettype wire

// ---- kbr_kbd_model.sv ----
// Purpose: Serial keyboard model
// Assumes: 800 ns link clock period
// Notes:   Lines idle high, driven high by the model
`timescale 1ns/1ps
`default_nettype none
module kbr_kbd_model (
    output var logic kbd_clock,
    output var logic kbd_data
);
    initial begin
        kbd_clock = 1'b1;
        kbd_data = 1'b1;
    end
    // Start low, data LSB first, odd parity, stop high
    task send(input logic [7:0] b);
        logic [10:0] f;
        f = {1'b1, ~^b, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            kbd_data = f[i];
            #200 kbd_clock = 1'b0;
            #400 kbd_clock = 1'b1;
            #200;
        end
        kbd_data = 1'b1;
        #60000;
    endtask
    // One-cycle dip that a debounced input must ignore
    task glitch;
        kbd_clock = 1'b0;
        #100 kbd_clock = 1'b1;
    endtask
endmodule
`default_nettype wire

// ---- kbr_map.vh ----
// Purpose: Constants for the keyboard serial receiver
// Assumes: 10 MHz system clock
// Notes:   Header holds definitions only
`ifndef KBR_MAP_VH
`define KBR_MAP_VH

`define KBR_CLK_HZ        10000000
`define KBR_KBD_HZ        10000
// Half of a keyboard clock period, in system cycles (longest time, rounds down)
`define KBR_IDLE_CYC      (`KBR_CLK_HZ / `KBR_KBD_HZ / 2)
`define KBR_DEB_CYC       4
`define KBR_FRAME_BITS    11
`define KBR_DATA_LSB      1
`define KBR_FIFO_DEPTH    16
`define KBR_PTR_W         4
`define KBR_CNT_W         5
`define KBR_IDLE_W        10

`endif

// ---- kbr_receiver.v ----
// Purpose: Serial keyboard receiver with byte queue and host read port
// Assumes: Single 10 MHz clock; keyboard clock sampled as plain input
// Notes:   Host read bus is tri-state split into in/out/enable
`timescale 1ns/1ps
`default_nettype none
`include "kbr_map.vh"

module kbr_receiver (
    input  wire       clk,
    input  wire       rst,
    input  wire       kbd_clock_in,
    input  wire       kbd_data_in,
    input  wire       irq_clear_in,
    input  wire       host_select,
    input  wire [7:0] host_read_bus_in,
    output reg  [7:0] host_read_bus_out,
    output reg        host_read_bus_oe,
    output reg        valid,
    output reg        interrupt,
    output reg        fifo_nonempty
);

    // ------------------------------------------------------------
    // Constants at register width
    // ------------------------------------------------------------
    localparam [31:0]            DEB_LAST_W = `KBR_DEB_CYC - 1;
    localparam [31:0]            IDLE_END_W = `KBR_IDLE_CYC;
    localparam [31:0]            DEPTH_W    = `KBR_FIFO_DEPTH;
    localparam [31:0]            FRAME_W    = `KBR_FRAME_BITS;
    localparam [2:0]             DEB_LAST   = DEB_LAST_W[2:0];
    localparam [`KBR_IDLE_W-1:0] IDLE_END   = IDLE_END_W[`KBR_IDLE_W-1:0];
    localparam [`KBR_PTR_W:0]    FULL_CNT   = DEPTH_W[`KBR_PTR_W:0];
    localparam [`KBR_CNT_W-1:0]  FRAME_N    = FRAME_W[`KBR_CNT_W-1:0];

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // One debounce step, returns {level, count}; a level only moves after
    // it has disagreed for the full count, so short spikes vanish
    function [3:0] deb_step;
        input       raw;
        input       level;
        input [2:0] count;
        begin
            if (raw == level) begin
                deb_step = {level, 3'h0};
            end else if (count == DEB_LAST) begin
                deb_step = {raw, 3'h0};
            end else begin
                deb_step = {level, count + 3'h1};
            end
        end
    endfunction

    // Aligns a frame of n bits so its start bit lands at bit 0;
    // leftovers of the previous frame below it are shifted out
    function [7:0] frame_byte;
        input [`KBR_FRAME_BITS-1:0] frame;
        input [`KBR_CNT_W-1:0]      n;
        reg   [`KBR_FRAME_BITS-1:0] aligned;
        begin
            if (n >= FRAME_N) begin
                aligned = frame;
            end else begin
                aligned = frame >> (FRAME_N - n);
            end
            frame_byte = aligned[`KBR_DATA_LSB+7:`KBR_DATA_LSB];
        end
    endfunction

    // Queue occupancy after one cycle of push and pop
    function [`KBR_PTR_W:0] next_count;
        input [`KBR_PTR_W:0] count;
        input                inc;
        input                dec;
        begin
            next_count = count + {{`KBR_PTR_W{1'b0}}, inc} - {{`KBR_PTR_W{1'b0}}, dec};
        end
    endfunction

    // ------------------------------------------------------------
    // Synchronisers and debounce
    // ------------------------------------------------------------
    reg [1:0]  kc_sync_r;
    reg [1:0]  kd_sync_r;
    reg [1:0]  sel_sync_r;
    reg [1:0]  clr_sync_r;
    reg [2:0]  kc_cnt_r;
    reg [2:0]  kd_cnt_r;
    reg        kc_deb_r;
    reg        kd_deb_r;
    reg        kc_prev_r;
    reg        sel_prev_r;

    // Filter ignores glitches shorter than the debounce count
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            kc_sync_r  <= 2'b11;
            kd_sync_r  <= 2'b11;
            sel_sync_r <= 2'b00;
            clr_sync_r <= 2'b00;
            kc_cnt_r   <= 3'h0;
            kd_cnt_r   <= 3'h0;
            kc_deb_r   <= 1'b1;
            kd_deb_r   <= 1'b1;
            kc_prev_r  <= 1'b1;
            sel_prev_r <= 1'b0;
        end else begin
            kc_sync_r  <= {kc_sync_r[0], kbd_clock_in};
            kd_sync_r  <= {kd_sync_r[0], kbd_data_in};
            sel_sync_r <= {sel_sync_r[0], host_select};
            clr_sync_r <= {clr_sync_r[0], irq_clear_in};
            {kc_deb_r, kc_cnt_r} <= deb_step(kc_sync_r[1], kc_deb_r, kc_cnt_r);
            {kd_deb_r, kd_cnt_r} <= deb_step(kd_sync_r[1], kd_deb_r, kd_cnt_r);
            kc_prev_r  <= kc_deb_r;
            sel_prev_r <= sel_sync_r[1];
        end
    end

    wire kc_fall  = kc_prev_r & ~kc_deb_r;
    wire sel_rise = sel_sync_r[1] & ~sel_prev_r;

    // ------------------------------------------------------------
    // Frame shifter and end of frame
    // ------------------------------------------------------------
    reg [`KBR_FRAME_BITS-1:0] shift_r;
    reg [`KBR_CNT_W-1:0]      nbits_r;
    reg [`KBR_IDLE_W-1:0]     idle_r;
    reg                       busy_r;
    reg                       done_r;
    reg [7:0]                 rx_byte_r;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_r   <= 11'h000;
            nbits_r   <= 5'h00;
            idle_r    <= 10'h000;
            busy_r    <= 1'b0;
            done_r    <= 1'b0;
            rx_byte_r <= 8'h00;
        end else begin
            done_r <= 1'b0;
            if (kc_fall) begin
                // First bit arrives at the top and moves down
                shift_r <= {kd_deb_r, shift_r[`KBR_FRAME_BITS-1:1]};
                // Count saturates so a noisy burst cannot wrap to a short frame
                if (nbits_r != 5'h1f) begin
                    nbits_r <= nbits_r + 5'h01;
                end
                busy_r  <= 1'b1;
                idle_r  <= 10'h000;
            end else if (busy_r && kc_deb_r) begin
                if (idle_r == IDLE_END) begin
                    done_r    <= 1'b1;
                    rx_byte_r <= frame_byte(shift_r, nbits_r);
                    busy_r    <= 1'b0;
                    nbits_r   <= 5'h00;
                    idle_r    <= 10'h000;
                end else begin
                    idle_r <= idle_r + 10'h001;
                end
            end else begin
                idle_r <= 10'h000;
            end
        end
    end

    // ------------------------------------------------------------
    // Byte queue and host port
    // ------------------------------------------------------------
    reg [7:0]            mem_r [0:`KBR_FIFO_DEPTH-1];
    reg [`KBR_PTR_W-1:0] wr_r;
    reg [`KBR_PTR_W-1:0] rd_r;
    reg [`KBR_PTR_W:0]   cnt_r;
    wire                 push    = done_r && (cnt_r != FULL_CNT);
    wire                 pop     = sel_rise && (cnt_r != 5'h00);
    wire [`KBR_PTR_W:0]  cnt_nxt = next_count(cnt_r, push, pop);
    integer i;

    // A full queue drops new bytes; keyboard has no back-pressure
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            for (i = 0; i < `KBR_FIFO_DEPTH; i = i + 1) begin
                mem_r[i] <= 8'h00;
            end
            wr_r              <= 4'h0;
            rd_r              <= 4'h0;
            cnt_r             <= 5'h00;
            valid             <= 1'b0;
            interrupt         <= 1'b0;
            fifo_nonempty     <= 1'b0;
            host_read_bus_out <= 8'h00;
            host_read_bus_oe  <= 1'b0;
        end else begin
            valid <= done_r;
            if (push) begin
                mem_r[wr_r] <= rx_byte_r;
                wr_r        <= wr_r + 4'h1;
            end
            if (pop) begin
                host_read_bus_out <= mem_r[rd_r];
                rd_r              <= rd_r + 4'h1;
            end
            cnt_r         <= cnt_nxt;
            fifo_nonempty <= (cnt_nxt != 5'h00);
            // Set wins over clear
            if (done_r) begin
                interrupt <= 1'b1;
            end else if (clr_sync_r[1]) begin
                interrupt <= 1'b0;
            end
            host_read_bus_oe <= sel_sync_r[1];
        end
    end

endmodule
`default_nettype wire

// ---- kbr_receiver_bench.sv ----
// Purpose: Self-checking bench for kbr_receiver
// Assumes: 10 MHz clk, reset 2 cycles
// Notes:   Read waits are the fixed 3-cycle latency plus margin
`timescale 1ns/1ps
`default_nettype none
module kbr_receiver_bench;
    logic       clk = 1'b0, rst = 1'b1, clr = 1'b0, sel = 1'b0;
    wire logic  kc, kd, oe, vld, irq, ne;
    wire logic [7:0] bo;
    int         n_errors = 0, samples_checked = 0, nv = 0;
    initial forever #50 clk = ~clk;
    always @(posedge clk) if (vld === 1'b1) nv <= nv + 1;
    kbr_kbd_model kbr_kbd_model_i (.kbd_clock(kc), .kbd_data(kd));
    kbr_receiver kbr_receiver_i (.clk(clk), .rst(rst), .kbd_clock_in(kc), .kbd_data_in(kd),
        .irq_clear_in(clr), .host_select(sel), .host_read_bus_in(oe ? bo : 8'h5a),
        .host_read_bus_out(bo), .host_read_bus_oe(oe), .valid(vld), .interrupt(irq),
        .fifo_nonempty(ne));
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task frame(input logic [7:0] b);
        int v0;
        // Keyboard lines move off the clock edge so sampling never races
        @(posedge clk);
        #25;
        v0 = nv;
        kbr_kbd_model_i.send(b);
        chk(8'(nv - v0), 8'h01);
        chk({7'h0, irq}, 8'h01);
    endtask
    task rd(input logic [7:0] exp, input logic ne_exp);
        @(posedge clk) sel <= 1'b1;
        repeat (5) @(posedge clk);
        #1 chk(bo, exp);
        chk({6'h0, oe, ne}, {7'h1, ne_exp});
        @(posedge clk) sel <= 1'b0;
        repeat (5) @(posedge clk);
        #1 chk({7'h0, oe}, 8'h00);
    endtask
    task irq_clr;
        @(posedge clk) clr <= 1'b1;
        repeat (4) @(posedge clk);
        clr <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk({7'h0, irq}, 8'h00);
    endtask
    task wrap_up;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #1000000;
        n_errors++;
        wrap_up;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #25;
        kbr_kbd_model_i.glitch;
        repeat (700) @(posedge clk);
        chk(8'(nv), 8'h00);
        frame(8'ha5);
        frame(8'h3c);
        irq_clr;
        frame(8'h81);
        rd(8'ha5, 1'b1);
        rd(8'h3c, 1'b1);
        rd(8'h81, 1'b0);
        rd(8'h81, 1'b0);
        wrap_up;
    end
endmodule
`default_nettype wire
